// *** hw/tsp_pkg.sv ***
/*
 tsp_pkg: constants shared by the serial audio port: register offsets,
 control field positions, reset values, mode and coding encodings, clock
 rate, frame-rate and frame-length tables and compander constants.
 Assumes a 250 MHz core clock and 32-bit word-aligned registers.
*/
package tsp_pkg;
   // core clock rate in hertz
   localparam int unsigned TSP_CLK_HZ = 32'h0EE6_B280;
   // register byte offsets
   localparam logic [7:0] TSP_OFF_CTRL = 8'h00;
   localparam logic [7:0] TSP_OFF_SLOTS = 8'h04;
   localparam logic [7:0] TSP_OFF_STATUS = 8'h08;
   localparam logic [7:0] TSP_OFF_TX0 = 8'h10;
   localparam logic [7:0] TSP_OFF_RX0 = 8'h20;
   // control field positions
   localparam int TSP_CTRL_EN = 0;
   localparam int TSP_CTRL_MASTER = 1;
   localparam int TSP_CTRL_MODE = 2;
   localparam int TSP_CTRL_TES = 4;
   localparam int TSP_CTRL_LOOP = 5;
   localparam int TSP_CTRL_HFW = 6;
   localparam int TSP_CTRL_ENC = 8;
   localparam int TSP_CTRL_RATE = 10;
   localparam int TSP_CTRL_BPF = 12;
   // reset values: disabled, slave, standard alignment, 32 bits, 8 kHz
   localparam logic [31:0] TSP_CTRL_RST = 32'h0000_2000;
   localparam logic [31:0] TSP_SLOTS_RST = 32'h0000_0000;
   // framing personalities
   localparam logic [1:0] TSP_MODE_I2S = 2'h0;
   localparam logic [1:0] TSP_MODE_LJ = 2'h1;
   localparam logic [1:0] TSP_MODE_PCM = 2'h2;
   localparam logic [1:0] TSP_MODE_GCI = 2'h3;
   // sample codings
   localparam logic [1:0] TSP_ENC_LIN = 2'h0;
   localparam logic [1:0] TSP_ENC_ALAW = 2'h1;
   localparam logic [1:0] TSP_ENC_MULAW = 2'h2;
   localparam logic [1:0] TSP_ENC_G722 = 2'h3;
   // compander constants
   localparam logic [15:0] TSP_MU_BIAS = 16'h0084;
   localparam logic [15:0] TSP_MU_OFS = 16'h0021;
   localparam logic [15:0] TSP_MU_CLIP = 16'h1FFF;
   localparam logic [7:0] TSP_A_XOR = 8'h55;
   localparam logic [15:0] TSP_A_RND = 16'h0008;
   localparam logic [15:0] TSP_A_SEG1 = 16'h0108;
   // frame rate in hertz for each rate code (8, 16, 48 kHz)
   function automatic logic [15:0] tsp_rate_hz(input logic [1:0] code);
      case (code)
         2'h1: return 16'h3E80;
         2'h2: return 16'hBB80;
         default: return 16'h1F40;
      endcase
   endfunction
   // bit clocks per frame for each frame-length code
   function automatic logic [10:0] tsp_bpf(input logic [3:0] code);
      case (code)
         4'h0: return 11'h008;
         4'h1: return 11'h010;
         4'h3: return 11'h040;
         4'h4: return 11'h060;
         4'h5: return 11'h080;
         4'h6: return 11'h0C0;
         4'h7: return 11'h100;
         4'h8: return 11'h180;
         4'h9: return 11'h200;
         4'hA: return 11'h400;
         default: return 11'h020;
      endcase
   endfunction
endpackage

// *** hw/tsp_port.sv ***
/*
 tsp_port: four-wire serial audio port with standard and left-justified
 stereo framing plus PCM and GCI timeslot framing, as clock master or
 slave, with a small register file on a plain strobe port.
 Assumes pins arrive asynchronous to clk_in and that the bit clock stays
 well below a quarter of the core clock rate.
*/
// Decided for this implementation: the register addresses and strobed register access.
// Contract
// - stereo out on tx line, in on rx
// - master drives clocks, slave takes them
// - frame rate 8, 16 or 48 kHz
// - driven word select has 50% duty
// - stereo bits travel MSB first
// - frame length programmable, 8 to 1024 bits
// - bits after a channel LSB are dropped
// - standard alignment: left low, one-bit delay
// - left-justified: left high, no delay
// - full duplex, with a serial loopback
// - each channel has its own 8-bit slot
// - A-law, mu-law, linear or G.722 per bus
// - linear sample uses slots N and N+1
// - narrowband and wideband linear frame rates
// - G.722 uses one slot at 8 kHz
// - half-frame mode adds second pair automatically
// - slave accepts any frame sync width
// - master frame sync is one bit wide
// - transmit edge falling (0) or rising (1)
// - GCI one clock per bit, no control bytes
// - GCI data aligned to frame sync rise
// - at most four channels per bus
`timescale 1ns/1ps
`default_nettype none
module tsp_port #(
   parameter int NCH = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // bit clock pin
   input wire logic bit_clk_in,
   output logic bit_clk_out,
   output logic bit_clk_oe_n_out,
   // frame sync / word select pin
   input wire logic frame_sync_in,
   output logic frame_sync_out,
   output logic frame_sync_oe_n_out,
   // serial data pins
   input wire logic serial_rx_line_in,
   output logic serial_tx_line_out,
   output logic serial_tx_oe_n_out
);
   import tsp_pkg::*;

   // the channel count is bounded by the slot register layout
   if (NCH < 1 || NCH > 4) begin : g_chk
      $error("tsp_port: NCH must be 1 to 4");
   end

   logic [31:0] ctrl_ff, slots_ff, tx_reg_ff [NCH], rx_reg_ff [NCH];
   logic [31:0] tx_hold_ff [NCH], rx_acc_ff [NCH];
   logic [15:0] frame_cnt_ff;
   logic bclk_s1_ff, bclk_s2_ff, fs_s1_ff, fs_s2_ff, rx_s1_ff, rx_s2_ff;
   logic sclk_prev_ff, ws_samp_ff, locked_ff, fall_d_ff, frame_d_ff;
   logic bclk_ff;
   logic [28:0] nco_ff;
   logic [29:0] nco_sum;
   logic [28:0] nco_inc;
   logic [10:0] pos_ff, nxt_pos, sp, bpf, half;
   logic [7:0] span;
   logic en, master, is_i2s, is_lj, tes, loop, hfw, lin, d;
   logic [1:0] mode, enc;
   logic sclk_lvl, rise, fall, frame_start, sync_hit, tx_evt, rx_evt;
   logic [10:0] sync_pos;
   logic hit_v [NCH];
   logic [4:0] idx_v [NCH];
   logic tx_bit, tx_any;

   // mu-law compression of a 16-bit linear sample
   function automatic logic [7:0] mu_enc(input logic [15:0] x);
      logic [15:0] m;
      logic [2:0] seg;
      m = x[15] ? 16'(~x + 16'h0001) : x;
      m = 16'((m >> 2) + TSP_MU_OFS);
      if (m > TSP_MU_CLIP) m = TSP_MU_CLIP;
      seg = 3'h0;
      for (int i = 0; i < 8; i++) if (m[i+5]) seg = 3'(i);
      m = m >> (seg + 3'h1);
      return {~x[15], ~seg, ~m[3:0]};
   endfunction

   // mu-law expansion back to 16-bit linear
   function automatic logic [15:0] mu_dec(input logic [7:0] code);
      logic [7:0] c;
      logic [15:0] t;
      c = ~code;
      t = 16'(({9'h000, c[3:0], 3'h0} + TSP_MU_BIAS) << c[6:4]);
      return c[7] ? 16'(TSP_MU_BIAS - t) : 16'(t - TSP_MU_BIAS);
   endfunction

   // A-law compression; negative values fold via one's complement
   function automatic logic [7:0] a_enc(input logic [15:0] x);
      logic [15:0] m;
      logic [2:0] seg;
      m = x[15] ? ~x : x;
      m = m >> 3;
      seg = 3'h0;
      for (int i = 0; i < 7; i++) if (m[i+5]) seg = 3'(i + 1);
      m = m >> ((seg == 3'h0) ? 3'h1 : seg);
      return {~x[15], seg, m[3:0]} ^ TSP_A_XOR;
   endfunction

   // A-law expansion back to 16-bit linear
   function automatic logic [15:0] a_dec(input logic [7:0] code);
      logic [7:0] c;
      logic [15:0] t;
      c = code ^ TSP_A_XOR;
      t = {8'h00, c[3:0], 4'h0};
      if (c[6:4] == 3'h0) t = 16'(t + TSP_A_RND);
      else t = 16'((t + TSP_A_SEG1) << (c[6:4] - 3'h1));
      return c[7] ? t : 16'(16'h0000 - t);
   endfunction

   // software words to wire form, one sample per 16-bit half
   function automatic logic [31:0] fmt_tx(input logic [31:0] v, input logic [1:0] e);
      case (e)
         TSP_ENC_ALAW: return {8'h00, a_enc(v[31:16]), 8'h00, a_enc(v[15:0])};
         TSP_ENC_MULAW: return {8'h00, mu_enc(v[31:16]), 8'h00, mu_enc(v[15:0])};
         default: return v; // linear and G.722 pass untouched
      endcase
   endfunction

   // wire form back to software words; G.722 bytes stay coded
   function automatic logic [31:0] fmt_rx(input logic [31:0] v, input logic [1:0] e);
      case (e)
         TSP_ENC_ALAW: return {a_dec(v[23:16]), a_dec(v[7:0])};
         TSP_ENC_MULAW: return {mu_dec(v[23:16]), mu_dec(v[7:0])};
         TSP_ENC_G722: return {8'h00, v[23:16], 8'h00, v[7:0]};
         default: return v;
      endcase
   endfunction

   // control fields; stereo framing ignores coding and edge select
   assign en = ctrl_ff[TSP_CTRL_EN];
   assign master = ctrl_ff[TSP_CTRL_MASTER];
   assign mode = ctrl_ff[TSP_CTRL_MODE +: 2];
   assign is_i2s = ~mode[1];
   assign is_lj = (mode == TSP_MODE_LJ);
   assign tes = ~is_i2s & ctrl_ff[TSP_CTRL_TES];
   assign loop = ctrl_ff[TSP_CTRL_LOOP];
   assign hfw = ctrl_ff[TSP_CTRL_HFW];
   assign enc = is_i2s ? TSP_ENC_LIN : ctrl_ff[TSP_CTRL_ENC +: 2];
   assign lin = (enc == TSP_ENC_LIN);
   assign bpf = tsp_bpf(ctrl_ff[TSP_CTRL_BPF +: 4]);
   assign half = bpf >> 1;
   assign span = 8'(bpf >> 4);
   // standard alignment and PCM lag the sync by one bit, GCI does not
   assign d = (mode == TSP_MODE_I2S) || (mode == TSP_MODE_PCM);

   // two-stage synchronisers for every pin input
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         {bclk_s1_ff, fs_s1_ff, rx_s1_ff} <= 3'h0;
         {bclk_s2_ff, fs_s2_ff, rx_s2_ff} <= 3'h0;
      end else begin
         {bclk_s1_ff, fs_s1_ff, rx_s1_ff} <= {bit_clk_in, frame_sync_in, serial_rx_line_in};
         {bclk_s2_ff, fs_s2_ff, rx_s2_ff} <= {bclk_s1_ff, fs_s1_ff, rx_s1_ff};
      end
   end

   // fractional divider: average bit rate is exactly rate times frame length
   assign nco_inc = 29'({12'h000, tsp_rate_hz(ctrl_ff[TSP_CTRL_RATE +: 2]), 1'b0} * {18'h0_0000, bpf});
   assign nco_sum = {1'b0, nco_ff} + {1'b0, nco_inc};
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !en || !master) begin
         nco_ff <= '0;
         bclk_ff <= 1'b0;
      end else if (nco_sum >= 30'(TSP_CLK_HZ)) begin
         nco_ff <= 29'(nco_sum - 30'(TSP_CLK_HZ));
         bclk_ff <= ~bclk_ff;
      end else begin
         nco_ff <= nco_sum[28:0];
      end
   end

   // edges of whichever bit clock is in charge
   assign sclk_lvl = master ? bclk_ff : bclk_s2_ff;
   assign rise = en & sclk_lvl & ~sclk_prev_ff;
   assign fall = en & ~sclk_lvl & sclk_prev_ff;
   assign tx_evt = tes ? rise : fall_d_ff;
   assign rx_evt = tes ? fall : rise;
   assign nxt_pos = (pos_ff >= 11'(bpf - 11'h001)) ? 11'h000 : 11'(pos_ff + 11'h001);
   assign frame_start = fall & (nxt_pos == 11'h000);
   // stereo syncs on each level change, slot modes on the rising edge only
   assign sync_hit = is_i2s ? (fs_s2_ff != ws_samp_ff) : (fs_s2_ff & ~ws_samp_ff);
   assign sync_pos = (is_i2s && (fs_s2_ff != is_lj)) ? half : 11'h000;

   // edge history and delayed strobes
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sclk_prev_ff <= 1'b0;
         fall_d_ff <= 1'b0;
         frame_d_ff <= 1'b0;
      end else begin
         sclk_prev_ff <= en & sclk_lvl;
         fall_d_ff <= fall;
         frame_d_ff <= frame_start;
      end
   end

   // bit position in the frame; slave pulls it onto the far sync
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !en) begin
         pos_ff <= 11'h000;
         ws_samp_ff <= 1'b0;
         locked_ff <= 1'b0;
      end else begin
         if (rise) ws_samp_ff <= fs_s2_ff;
         if (rise && !master && sync_hit) begin
            pos_ff <= sync_pos;
            locked_ff <= 1'b1;
         end else if (fall) begin
            pos_ff <= nxt_pos;
         end
      end
   end

   // position after the alignment lag, folded into the frame
   assign sp = (pos_ff >= {10'h000, d}) ? 11'(pos_ff - {10'h000, d})
                                        : 11'(pos_ff + bpf - {10'h000, d});

   // per channel: slot match, sample latch, capture and hand-off
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [7:0] dn;
      logic hit, w;
      logic [3:0] bi;
      logic [10:0] sh;
      always_comb begin
         dn = 8'(sp[10:3] - slots_ff[8*c +: 8]);
         sh = 11'(sp - half);
         hit = 1'b0;
         w = 1'b0;
         bi = 4'h0;
         if (is_i2s) begin
            // left owns the first half, right the second, up to 16 bits each
            if (c == 0 && sp < half && sp < 11'h010) begin
               hit = 1'b1;
               bi = sp[3:0];
            end else if (c == 1 && sp >= half && sh < 11'h010) begin
               hit = 1'b1;
               bi = sh[3:0];
            end
         end else if (dn == 8'h00) begin
            hit = 1'b1;
            bi = {1'b0, sp[2:0]};
         end else if (lin && dn == 8'h01) begin
            hit = 1'b1;
            bi = {1'b1, sp[2:0]};
         end else if (lin && hfw && dn == span) begin
            hit = 1'b1;
            w = 1'b1;
            bi = {1'b0, sp[2:0]};
         end else if (lin && hfw && dn == 8'(span + 8'h01)) begin
            hit = 1'b1;
            w = 1'b1;
            bi = {1'b1, sp[2:0]};
         end
      end
      assign hit_v[c] = hit;
      // first bit on the wire is the top bit of the sample
      assign idx_v[c] = {w, lin ? ~bi : {1'b0, ~bi[2:0]}};

      // software transmit word
      always_ff @(posedge clk_in) begin
         if (!rst_n_in) tx_reg_ff[c] <= 32'h0000_0000;
         else if (reg_wr_in && reg_addr_in == 8'(TSP_OFF_TX0 + 8'(4 * c))) tx_reg_ff[c] <= reg_wdata_in;
      end

      // latch at frame start so a late write never tears a sample
      always_ff @(posedge clk_in) begin
         if (!rst_n_in) tx_hold_ff[c] <= 32'h0000_0000;
         else if (frame_start) tx_hold_ff[c] <= fmt_tx(tx_reg_ff[c], enc);
      end

      // capture bits in place, publish one cycle after the frame wraps
      always_ff @(posedge clk_in) begin
         if (!rst_n_in) begin
            rx_acc_ff[c] <= 32'h0000_0000;
            rx_reg_ff[c] <= 32'h0000_0000;
         end else begin
            if (rx_evt && hit) rx_acc_ff[c][idx_v[c]] <= rx_s2_ff;
            if (frame_d_ff) rx_reg_ff[c] <= fmt_rx(rx_acc_ff[c], enc);
         end
      end
   end

   // lowest channel wins when two share a slot
   always_comb begin
      tx_bit = 1'b0;
      tx_any = 1'b0;
      for (int c = NCH - 1; c >= 0; c--) begin
         if (hit_v[c]) begin
            tx_any = 1'b1;
            tx_bit = tx_hold_ff[c][idx_v[c]];
         end
      end
   end

   // serial output; in slot modes without loopback, released between owned slots so others may share the bus
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !en) begin
         serial_tx_line_out <= 1'b0;
         serial_tx_oe_n_out <= 1'b1;
      end else if (tx_evt) begin
         serial_tx_line_out <= loop ? rx_s2_ff : tx_bit;
         serial_tx_oe_n_out <= ~(is_i2s | tx_any | loop);
      end
   end

   // master clock and sync pins, updated one cycle after the falling edge
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bit_clk_out <= 1'b0;
         bit_clk_oe_n_out <= 1'b1;
         frame_sync_out <= 1'b0;
         frame_sync_oe_n_out <= 1'b1;
      end else begin
         bit_clk_out <= bclk_ff;
         bit_clk_oe_n_out <= ~(en & master);
         frame_sync_oe_n_out <= ~(en & master);
         if (!en || !master) frame_sync_out <= 1'b0;
         else if (fall_d_ff && is_i2s) frame_sync_out <= (pos_ff >= half) ^ is_lj;
         else if (fall_d_ff) frame_sync_out <= (pos_ff == 11'h000);
      end
   end

   // control, slot map and frame counter
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_ff <= TSP_CTRL_RST;
         slots_ff <= TSP_SLOTS_RST;
      end else if (reg_wr_in) begin
         if (reg_addr_in == TSP_OFF_CTRL) ctrl_ff <= reg_wdata_in;
         if (reg_addr_in == TSP_OFF_SLOTS) slots_ff <= reg_wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !en) frame_cnt_ff <= 16'h0000;
      else if (frame_start) frame_cnt_ff <= 16'(frame_cnt_ff + 16'h0001);
   end

   // read data one cycle after the strobe; unmapped words read zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !reg_rd_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_addr_in == TSP_OFF_CTRL) begin
         reg_rdata_out <= ctrl_ff;
      end else if (reg_addr_in == TSP_OFF_SLOTS) begin
         reg_rdata_out <= slots_ff;
      end else if (reg_addr_in == TSP_OFF_STATUS) begin
         reg_rdata_out <= {frame_cnt_ff, 14'h0000, en, master | locked_ff};
      end else if (reg_addr_in[1:0] == 2'h0 && int'(reg_addr_in[3:2]) < NCH &&
                   reg_addr_in[7:4] == TSP_OFF_TX0[7:4]) begin
         reg_rdata_out <= tx_reg_ff[reg_addr_in[3:2]];
      end else if (reg_addr_in[1:0] == 2'h0 && int'(reg_addr_in[3:2]) < NCH &&
                   reg_addr_in[7:4] == TSP_OFF_RX0[7:4]) begin
         reg_rdata_out <= rx_reg_ff[reg_addr_in[3:2]];
      end else begin
         reg_rdata_out <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// *** tb/tsp_port_checker_assertions.sv ***
/* tsp_port_checker: pin timing checks for the serial audio port.
 Assumes it is bound to tsp_port and mirrors control writes seen on the register port. */
`timescale 1ns/1ps
`default_nettype none
module tsp_port_checker
   import tsp_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // register writes
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   // pins
   input wire logic bit_clk_out,
   input wire logic bit_clk_oe_n_out,
   input wire logic frame_sync_out,
   input wire logic frame_sync_oe_n_out,
   input wire logic serial_tx_line_out,
   input wire logic serial_tx_oe_n_out
);
   logic [31:0] ctrl_ff;
   logic [3:0] calm_ff;
   logic [1:0] edges_ff;
   logic bclk_q_ff;
   logic ws_q_ff;
   logic [2:0] since_fall_ff;
   logic [2:0] since_rise_ff;
   logic [11:0] half_cnt_ff;
   logic [11:0] last_cnt_ff;
   logic en;
   logic ms;
   logic slot;
   logic settled;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // decoded control mirror
   assign en = ctrl_ff[TSP_CTRL_EN];
   assign ms = ctrl_ff[TSP_CTRL_MASTER] & en;
   assign slot = ctrl_ff[TSP_CTRL_MODE + 1];
   assign settled = (calm_ff > 4'h7);
   // control mirror; edge count restarts on every control write so partial halves are skipped
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || (reg_wr_in && reg_addr_in == TSP_OFF_CTRL)) begin
         ctrl_ff <= rst_n_in ? reg_wdata_in : TSP_CTRL_RST;
         calm_ff <= 4'h0;
         edges_ff <= 2'h0;
      end else begin
         calm_ff <= (calm_ff == 4'hF) ? calm_ff : calm_ff + 4'h1;
         if (frame_sync_out != ws_q_ff && edges_ff != 2'h3) begin
            edges_ff <= edges_ff + 2'h1;
         end
      end
   end
   // distance to last bit clock edges, bit clock rises between sync edges
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bclk_q_ff <= 1'b0;
         ws_q_ff <= 1'b0;
         since_fall_ff <= 3'h7;
         since_rise_ff <= 3'h7;
         half_cnt_ff <= 12'h000;
         last_cnt_ff <= 12'h000;
      end else begin
         bclk_q_ff <= bit_clk_out;
         ws_q_ff <= frame_sync_out;
         since_fall_ff <= (bclk_q_ff && !bit_clk_out) ? 3'h0 : since_fall_ff + {2'h0, ~&since_fall_ff};
         since_rise_ff <= (!bclk_q_ff && bit_clk_out) ? 3'h0 : since_rise_ff + {2'h0, ~&since_rise_ff};
         if (frame_sync_out != ws_q_ff) begin
            last_cnt_ff <= half_cnt_ff;
            half_cnt_ff <= 12'h000;
         end else if (bit_clk_out && !bclk_q_ff) begin
            half_cnt_ff <= half_cnt_ff + 12'h001;
         end
      end
   end
   sequence s_released;
      bit_clk_oe_n_out [*3];
   endsequence
   sequence s_fall_soon;
      ##[0:4] $fell(bit_clk_out);
   endsequence
   sequence s_rise_soon;
      ##[0:4] $rose(bit_clk_out);
   endsequence
   a_oe_pair: assert property (bit_clk_oe_n_out == frame_sync_oe_n_out)
      else $error("clock and sync enables differ");
   a_slave_release: assert property (settled && !ms |-> bit_clk_oe_n_out && frame_sync_oe_n_out)
      else $error("clock pins driven outside master role");
   a_master_drive: assert property (settled && ms |-> !bit_clk_oe_n_out)
      else $error("master does not drive bit clock");
   a_released_low: assert property (s_released |-> !bit_clk_out && !frame_sync_out)
      else $error("released clock pins not low");
   a_tx_release: assert property (settled && !en |-> serial_tx_oe_n_out)
      else $error("tx driven while disabled");
   a_ws_duty: assert property (settled && ms && !slot && edges_ff == 2'h3 && $changed(frame_sync_out) |-> half_cnt_ff == last_cnt_ff)
      else $error("word select halves unequal");
   a_sync_width: assert property (ms && slot && edges_ff > 2'h1 && $fell(frame_sync_out) |-> half_cnt_ff == 12'h001)
      else $error("master sync not one bit wide");
   a_ws_on_fall: assert property (settled && ms && !slot && $changed(frame_sync_out) |-> (since_fall_ff < 3'h6) or s_fall_soon)
      else $error("word select moved away from falling edge");
   a_tx_fall: assert property (ms && slot && !ctrl_ff[TSP_CTRL_TES] && !serial_tx_oe_n_out && $changed(serial_tx_line_out) |-> (since_fall_ff < 3'h6) or s_fall_soon)
      else $error("tx moved away from falling edge");
   a_tx_rise: assert property (ms && slot && ctrl_ff[TSP_CTRL_TES] && !serial_tx_oe_n_out && $changed(serial_tx_line_out) |-> (since_rise_ff < 3'h6) or s_rise_soon)
      else $error("tx moved away from rising edge");
endmodule
bind tsp_port tsp_port_checker i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .bit_clk_out(bit_clk_out), .bit_clk_oe_n_out(bit_clk_oe_n_out),
   .frame_sync_out(frame_sync_out), .frame_sync_oe_n_out(frame_sync_oe_n_out),
   .serial_tx_line_out(serial_tx_line_out), .serial_tx_oe_n_out(serial_tx_oe_n_out));
`default_nettype wire

// *** tb/tsp_codec_model.sv ***
/* tsp_codec_model: far-end codec acting as clock master towards the port.
 Assumes the bench calls play for each burst; the bit clock idles high between bursts. */
`timescale 1ns/1ps
`default_nettype none
module tsp_codec_model (
   // pins towards the port
   input wire logic dut_tx_in,
   output logic bclk_out,
   output logic fs_out,
   output logic sdi_out
);
   // idle levels
   initial begin
      bclk_out = 1'b1;
      fs_out = 1'b0;
      sdi_out = 1'b0;
   end
   // nfr frames of nb bits, then one trailing fall so the last frame wraps
   task automatic play(input logic [63:0] pat, input int shape, input int fsw, input int nb,
         input int nfr, output logic [63:0] cap);
      #1.3;
      for (int f = 0; f <= nfr; f++) begin
         for (int k = 0; k < nb; k++) begin
            if (f == nfr && k > 0) break;
            bclk_out = 1'b0;
            fs_out = (shape == 2) ? (k < fsw) : ((k >= nb / 2) ^ (shape == 1));
            sdi_out = pat[63 - k];
            #24;
            bclk_out = 1'b1;
            #23;
            cap[63 - k] = dut_tx_in;
            #1;
         end
      end
      // the data line keeps no stale value once the burst is over
      fs_out = (shape == 1);
      sdi_out = ~sdi_out;
   endtask
endmodule
`default_nettype wire

// *** tb/tsp_port_bench.sv ***
/* tsp_port_bench: register and serial frame tests of the audio port.
 Assumes the codec model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tsp_port_bench;
   import tsp_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0000_0000;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out;
   logic bit_clk_out, bit_clk_oe_n_out, frame_sync_out, frame_sync_oe_n_out;
   logic serial_tx_line_out, serial_tx_oe_n_out, p_bclk, p_fs, p_sdi;
   logic [31:0] d;
   logic [63:0] cap;
   int error_cnt = 0;
   int n_compared = 0;
   int cycles = 0;
   // each pin resolves to whichever side has its enable on
   wire logic bclk_w = bit_clk_oe_n_out ? p_bclk : bit_clk_out;
   wire logic fs_w = frame_sync_oe_n_out ? p_fs : frame_sync_out;
   always #2 clk_in = ~clk_in;
   tsp_port i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .bit_clk_in(bclk_w), .bit_clk_out(bit_clk_out),
      .bit_clk_oe_n_out(bit_clk_oe_n_out), .frame_sync_in(fs_w), .frame_sync_out(frame_sync_out),
      .frame_sync_oe_n_out(frame_sync_oe_n_out), .serial_rx_line_in(p_sdi),
      .serial_tx_line_out(serial_tx_line_out), .serial_tx_oe_n_out(serial_tx_oe_n_out));
   tsp_codec_model i_codec (.dut_tx_in(serial_tx_line_out), .bclk_out(p_bclk), .fs_out(p_fs),
      .sdi_out(p_sdi));
   task automatic stop_test();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      v = reg_rdata_out;
   endtask
   // slave frames from the codec; in 64-bit frames the bits after each 16-bit sample are junk to be dropped
   task automatic slave_case(input logic [31:0] ctrl, input logic [31:0] slots, input int shape,
         input int fsw, input bit dl, input bit hfw, input bit rxc, input int nb);
      logic [63:0] s_rx;
      logic [63:0] s_tx;
      s_rx = (nb == 64) ? 64'hA5C3_FFFF_3C96_FFFF : 64'hA5C3_3C96_0000_0000;
      s_tx = (nb == 64) ? 64'h9B17_0000_6E42_0000 : 64'h9B17_6E42_0000_0000;
      wr(TSP_OFF_CTRL, 32'h0000_0000);
      wr(TSP_OFF_SLOTS, slots);
      wr(TSP_OFF_TX0, hfw ? 32'h6E42_9B17 : 32'h0000_9B17);
      wr(TSP_OFF_TX0 + 8'h04, 32'h0000_6E42);
      wr(TSP_OFF_CTRL, ctrl | 32'h0000_0001);
      i_codec.play(dl ? {s_rx[64 - nb], s_rx[63:1]} : s_rx, shape, fsw, nb, 4, cap);
      if (dl) s_tx = {s_tx[64 - nb], s_tx[63:1]};
      chk(cap[63:32], s_tx[63:32]);
      if (nb == 64) chk(cap[31:0], s_tx[31:0]);
      if (rxc) begin
         rd(TSP_OFF_RX0, d);
         chk(hfw ? d : {16'h0000, d[15:0]}, hfw ? 32'h3C96_A5C3 : 32'h0000_A5C3);
         rd(TSP_OFF_RX0 + 8'h04, d);
         if (!hfw) chk({16'h0000, d[15:0]}, 32'h0000_3C96);
      end
   endtask
   // master frame: one whole frame measured between sync rises
   task automatic master_case(input logic [31:0] ctrl, input int per, input bit slot);
      int hi = 0, lo = 0, rh = 0, rt = 0, n = 0;
      logic fs_q = 1'b1, bc_q = 1'b1;
      wr(TSP_OFF_CTRL, ctrl | 32'h0000_0003);
      while (n < 2) begin
         @(negedge clk_in);
         if (frame_sync_out && !fs_q) n++;
         if (n == 1 && frame_sync_out) hi++;
         if (n == 1 && !frame_sync_out) lo++;
         if (n == 1 && bit_clk_out && !bc_q) rt++;
         if (n == 1 && bit_clk_out && !bc_q && frame_sync_out) rh++;
         fs_q = frame_sync_out;
         bc_q = bit_clk_out;
      end
      chk(rt, 32);
      chk({31'h0, hi + lo >= per - 2 && hi + lo <= per + 2}, 32'h1);
      if (slot) chk(rh, 1);
      else chk({31'h0, hi - lo <= 2 && lo - hi <= 2}, 32'h1);
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(TSP_OFF_CTRL, d);
      chk(d, TSP_CTRL_RST);
      rd(TSP_OFF_SLOTS, d);
      chk(d, TSP_SLOTS_RST);
      rd(8'h0C, d);
      chk(d, 32'h0000_0000);
      wr(TSP_OFF_RX0, 32'hFFFF_FFFF);
      rd(TSP_OFF_RX0, d);
      chk(d, 32'h0000_0000);
      slave_case(32'h0000_3000, 32'h0, 0, 0, 1'b1, 1'b0, 1'b1, 64);
      rd(TSP_OFF_STATUS, d);
      chk(d & 32'h0000_0003, 32'h0000_0003);
      slave_case(32'h0000_2004, 32'h0, 1, 0, 1'b0, 1'b0, 1'b1, 32);
      slave_case(32'h0000_2008, 32'h0002_0200, 2, 3, 1'b1, 1'b0, 1'b1, 32);
      slave_case(32'h0000_200C, 32'h0002_0200, 2, 1, 1'b0, 1'b0, 1'b1, 32);
      slave_case(32'h0000_2048, 32'h0, 2, 2, 1'b1, 1'b1, 1'b1, 32);
      slave_case(32'h0000_2018, 32'h0002_0200, 2, 1, 1'b1, 1'b0, 1'b0, 32);
      master_case(32'h0000_2800, 250_000_000 / 48_000, 1'b0);
      master_case(32'h0000_2808, 250_000_000 / 48_000, 1'b1);
      master_case(32'h0000_241C, 250_000_000 / 16_000, 1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
